// File: core/alm_pkg.sv
// Constants for the access-control layer-4 field matcher
package alm_pkg;
  // Register byte offsets
  localparam logic [5:0] ALM_REG_PROTO  = 6'h00;
  localparam logic [5:0] ALM_REG_ICMP   = 6'h04;
  localparam logic [5:0] ALM_REG_FLAGS  = 6'h08;
  localparam logic [5:0] ALM_REG_PMODE  = 6'h0C;
  localparam logic [5:0] ALM_REG_PORT0  = 6'h10;
  localparam logic [5:0] ALM_REG_STATUS = 6'h20;
  localparam int         ALM_ADDR_W     = 6;
  localparam int         ALM_NPORT      = 4;
  localparam int         ALM_NFLAG      = 6;
  // Field positions
  localparam int ALM_PROTO_SEL_LSB = 0;
  localparam int ALM_TTL_MODE_LSB  = 4;
  localparam int ALM_ICMP_TEN_BIT  = 0;
  localparam int ALM_ICMP_CEN_BIT  = 1;
  localparam int ALM_ICMP_TYPE_LSB = 8;
  localparam int ALM_ICMP_CODE_LSB = 16;
  localparam int ALM_PORT_HI_LSB   = 16;
  localparam int ALM_STAT_HIT_BIT  = 16;
  // Protocol selection codes
  localparam logic [2:0] ALM_SEL_ANY   = 3'h0;
  localparam logic [2:0] ALM_SEL_ICMP  = 3'h1;
  localparam logic [2:0] ALM_SEL_UDP   = 3'h2;
  localparam logic [2:0] ALM_SEL_TCP   = 3'h3;
  localparam logic [2:0] ALM_SEL_OTHER = 3'h4;
  // IPv4 protocol numbers
  localparam logic [7:0] ALM_IPP_ICMP = 8'h01;
  localparam logic [7:0] ALM_IPP_TCP  = 8'h06;
  localparam logic [7:0] ALM_IPP_UDP  = 8'h11;
  // Port modes
  localparam logic [1:0] ALM_PM_ANY   = 2'h0;
  localparam logic [1:0] ALM_PM_EXACT = 2'h1;
  localparam logic [1:0] ALM_PM_RANGE = 2'h2;
  // Flag and TTL modes
  localparam logic [1:0] ALM_FM_ANY   = 2'h0;
  localparam logic [1:0] ALM_FM_SET   = 2'h1;
  localparam logic [1:0] ALM_FM_CLEAR = 2'h2;
  localparam logic [1:0] ALM_TM_ANY   = 2'h0;
  localparam logic [1:0] ALM_TM_NONZ  = 2'h1;
  localparam logic [1:0] ALM_TM_ZERO  = 2'h2;
  // AXI responses
  localparam logic [1:0] ALM_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ALM_RESP_SLVERR = 2'h2;
  // Reset values
  localparam logic [31:0] ALM_RST_WORD = 32'h0000_0000;
  localparam logic [15:0] ALM_RST_PORT = 16'h0000;
endpackage

// File: core/alm_port_cmp.sv
// One port condition: any, exact or inclusive range
`timescale 1ns/100ps
module alm_port_cmp
  import alm_pkg::*;
(
  input  wire logic [1:0]  mode,
  input  wire logic [15:0] lo,
  input  wire logic [15:0] hi,
  input  wire logic [15:0] port,
  output logic             ok
);
  always_comb begin
    case (mode)
      ALM_PM_EXACT: ok = (port == lo);
      ALM_PM_RANGE: ok = (port >= lo) && (port <= hi); // [R15]
      default:      ok = 1'b1;
    endcase
  end
endmodule

// File: core/alm_flag_cmp.sv
// One three-way TCP flag condition
`timescale 1ns/100ps
module alm_flag_cmp
  import alm_pkg::*;
(
  input  wire logic [1:0] mode,
  input  wire logic       flag,
  output logic            ok
);
  always_comb begin
    case (mode)
      ALM_FM_SET:   ok = flag;
      ALM_FM_CLEAR: ok = !flag;
      default:      ok = 1'b1;
    endcase
  end
endmodule

// File: core/alm_matcher.sv
// Layer-4 match logic for one access-control entry with AXI4-Lite registers
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/100ps
// Functional notes
// R1: ICMP type: any or exact 8-bit value
// R2: ICMP code: any or exact 8-bit value
// R3: UDP source port: any, exact or range
// R4: UDP destination port: any, exact or range
// R5: TCP source port: any, exact or range
// R6: TCP destination port: any, exact or range
// R7: FIN flag: any, must be set, must clear
// R8: SYN flag: any, must be set, must clear
// R9: RST flag: any, must be set, must clear
// R10: PSH flag: any, must be set, must clear
// R11: ACK flag: any, must be set, must clear
// R12: URG flag: any, must be set, must clear
// R13: TTL: any, non-zero or zero
// R14: Protocol conditions only under matching protocol selection
// R15: Range bounds are both inclusive
// R16: Hit only when all active conditions hold
module alm_matcher
  import alm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        frm_valid,
  input  wire logic        frm_ipv4,
  input  wire logic [7:0]  frm_proto,
  input  wire logic [7:0]  frm_icmp_type,
  input  wire logic [7:0]  frm_icmp_code,
  input  wire logic [15:0] frm_src_port,
  input  wire logic [15:0] frm_dst_port,
  input  wire logic [5:0]  frm_tcp_flags,
  input  wire logic [7:0]  frm_ttl,
  output logic             match_valid,
  output logic             match_hit
);

  ////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic is_mapped(input logic [5:0] a);
    is_mapped = (a[1:0] == 2'h0) && (a <= ALM_REG_STATUS);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = strb[b] ? data[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Configuration state

  logic [2:0]  proto_sel;
  logic [1:0]  ttl_mode;
  logic        icmp_type_en;
  logic        icmp_code_en;
  logic [7:0]  icmp_type;
  logic [7:0]  icmp_code;
  logic [11:0] flag_mode;
  logic [7:0]  port_mode;
  logic [15:0] port_lo [0:ALM_NPORT-1];
  logic [15:0] port_hi [0:ALM_NPORT-1];
  logic [15:0] hit_count;
  logic        last_hit;

  ////////////////////////////////////////////////////////////////////////
  // Write channel

  logic        aw_held;
  logic        w_held;
  logic [5:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        do_write;

  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held       <= 1'b0;
      aw_addr       <= 6'h00;
      s_axi_awready <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end else if (!aw_held && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      w_held       <= 1'b0;
      w_data       <= ALM_RST_WORD;
      w_strb       <= 4'h0;
      s_axi_wready <= 1'b0;
    end else begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (do_write) begin
        w_held <= 1'b0;
      end else if (!w_held && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Response is held until the master takes it, so only one write is open
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ALM_RESP_OKAY;
    end else begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= is_mapped(aw_addr) ? ALM_RESP_OKAY : ALM_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file; reset puts every condition to any

  logic [31:0] cur_word;

  always_comb begin
    cur_word = ALM_RST_WORD;
    case (aw_addr)
      ALM_REG_PROTO: begin
        cur_word[ALM_PROTO_SEL_LSB +: 3] = proto_sel;
        cur_word[ALM_TTL_MODE_LSB +: 2]  = ttl_mode;
      end
      ALM_REG_ICMP: begin
        cur_word[ALM_ICMP_TEN_BIT]        = icmp_type_en;
        cur_word[ALM_ICMP_CEN_BIT]        = icmp_code_en;
        cur_word[ALM_ICMP_TYPE_LSB +: 8]  = icmp_type;
        cur_word[ALM_ICMP_CODE_LSB +: 8]  = icmp_code;
      end
      ALM_REG_FLAGS: cur_word[11:0] = flag_mode;
      ALM_REG_PMODE: cur_word[7:0]  = port_mode;
      default: begin
        if (aw_addr[5:4] == 2'h1) begin
          cur_word[15:0]                 = port_lo[aw_addr[3:2]];
          cur_word[ALM_PORT_HI_LSB +: 16] = port_hi[aw_addr[3:2]];
        end
      end
    endcase
  end

  logic [31:0] new_word;

  assign new_word = merge(cur_word, w_data, w_strb);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      proto_sel    <= ALM_SEL_ANY;  // [R14]
      ttl_mode     <= ALM_TM_ANY;   // [R13]
      icmp_type_en <= 1'b0;         // [R1]
      icmp_code_en <= 1'b0;         // [R2]
      icmp_type    <= 8'h00;
      icmp_code    <= 8'h00;
      flag_mode    <= 12'h000;      // [R7] [R8] [R9] [R10] [R11] [R12]
      port_mode    <= 8'h00;        // [R3] [R4] [R5] [R6]
      for (int i = 0; i < ALM_NPORT; i++) begin
        port_lo[i] <= ALM_RST_PORT;
        port_hi[i] <= ALM_RST_PORT;
      end
    end else if (do_write && is_mapped(aw_addr)) begin
      case (aw_addr)
        ALM_REG_PROTO: begin
          proto_sel <= new_word[ALM_PROTO_SEL_LSB +: 3];
          ttl_mode  <= new_word[ALM_TTL_MODE_LSB +: 2];
        end
        ALM_REG_ICMP: begin
          icmp_type_en <= new_word[ALM_ICMP_TEN_BIT];
          icmp_code_en <= new_word[ALM_ICMP_CEN_BIT];
          icmp_type    <= new_word[ALM_ICMP_TYPE_LSB +: 8];
          icmp_code    <= new_word[ALM_ICMP_CODE_LSB +: 8];
        end
        ALM_REG_FLAGS: flag_mode <= new_word[11:0];
        ALM_REG_PMODE: port_mode <= new_word[7:0];
        default: begin
          if (aw_addr[5:4] == 2'h1) begin
            port_lo[aw_addr[3:2]] <= new_word[15:0];
            port_hi[aw_addr[3:2]] <= new_word[ALM_PORT_HI_LSB +: 16];
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read channel

  logic [31:0] rd_word;

  always_comb begin
    rd_word = ALM_RST_WORD;
    case (s_axi_araddr)
      ALM_REG_PROTO: begin
        rd_word[ALM_PROTO_SEL_LSB +: 3] = proto_sel;
        rd_word[ALM_TTL_MODE_LSB +: 2]  = ttl_mode;
      end
      ALM_REG_ICMP: begin
        rd_word[ALM_ICMP_TEN_BIT]       = icmp_type_en;
        rd_word[ALM_ICMP_CEN_BIT]       = icmp_code_en;
        rd_word[ALM_ICMP_TYPE_LSB +: 8] = icmp_type;
        rd_word[ALM_ICMP_CODE_LSB +: 8] = icmp_code;
      end
      ALM_REG_FLAGS:  rd_word[11:0] = flag_mode;
      ALM_REG_PMODE:  rd_word[7:0]  = port_mode;
      ALM_REG_STATUS: begin
        rd_word[15:0]             = hit_count;
        rd_word[ALM_STAT_HIT_BIT] = last_hit;
      end
      default: begin
        if (s_axi_araddr[5:4] == 2'h1) begin
          rd_word[15:0]                  = port_lo[s_axi_araddr[3:2]];
          rd_word[ALM_PORT_HI_LSB +: 16] = port_hi[s_axi_araddr[3:2]];
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= ALM_RST_WORD;
      s_axi_rresp   <= ALM_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= is_mapped(s_axi_araddr) ? rd_word : ALM_RST_WORD;
        s_axi_rresp   <= is_mapped(s_axi_araddr) ? ALM_RESP_OKAY : ALM_RESP_SLVERR;
      end else if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end else begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Protocol selection

  logic is_icmp;
  logic is_udp;
  logic is_tcp;
  logic proto_ok;

  assign is_icmp = frm_ipv4 && (frm_proto == ALM_IPP_ICMP);
  assign is_udp  = frm_ipv4 && (frm_proto == ALM_IPP_UDP);
  assign is_tcp  = frm_ipv4 && (frm_proto == ALM_IPP_TCP);

  always_comb begin
    case (proto_sel)
      ALM_SEL_ICMP:  proto_ok = is_icmp;
      ALM_SEL_UDP:   proto_ok = is_udp;
      ALM_SEL_TCP:   proto_ok = is_tcp;
      ALM_SEL_OTHER: proto_ok = frm_ipv4 && !is_icmp && !is_udp && !is_tcp;
      default:       proto_ok = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // ICMP fields

  logic icmp_ok;

  // Type and code only count when ICMP is selected
  assign icmp_ok = (proto_sel != ALM_SEL_ICMP) ||                         // [R14]
                   ((!icmp_type_en || (frm_icmp_type == icmp_type)) &&     // [R1]
                    (!icmp_code_en || (frm_icmp_code == icmp_code)));      // [R2]

  ////////////////////////////////////////////////////////////////////////
  // Port conditions: 0 UDP src, 1 UDP dst, 2 TCP src, 3 TCP dst

  logic [ALM_NPORT-1:0] port_ok;

  for (genvar g = 0; g < ALM_NPORT; g++) begin : g_port
    alm_port_cmp u_cmp (
      .mode (port_mode[2*g +: 2]),
      .lo   (port_lo[g]),
      .hi   (port_hi[g]),
      .port ((g % 2 == 0) ? frm_src_port : frm_dst_port),
      .ok   (port_ok[g])
    ); // [R3] [R4] [R5] [R6]
  end

  logic udp_ok;
  logic tcp_ports_ok;

  assign udp_ok       = (proto_sel != ALM_SEL_UDP) || (port_ok[0] && port_ok[1]); // [R3] [R4] [R14]
  assign tcp_ports_ok = port_ok[2] && port_ok[3];                                 // [R5] [R6]

  ////////////////////////////////////////////////////////////////////////
  // TCP flags, bit 0 FIN up to bit 5 URG

  logic [ALM_NFLAG-1:0] flag_ok;

  for (genvar g = 0; g < ALM_NFLAG; g++) begin : g_flag
    alm_flag_cmp u_flag (
      .mode (flag_mode[2*g +: 2]),
      .flag (frm_tcp_flags[g]),
      .ok   (flag_ok[g])
    ); // [R7] [R8] [R9] [R10] [R11] [R12]
  end

  logic tcp_ok;

  assign tcp_ok = (proto_sel != ALM_SEL_TCP) || (tcp_ports_ok && (&flag_ok)); // [R14]

  ////////////////////////////////////////////////////////////////////////
  // Time to live; a non-IPv4 frame cannot satisfy either TTL test

  logic ttl_ok;

  always_comb begin
    case (ttl_mode)
      ALM_TM_NONZ: ttl_ok = frm_ipv4 && (frm_ttl != 8'h00); // [R13]
      ALM_TM_ZERO: ttl_ok = frm_ipv4 && (frm_ttl == 8'h00); // [R13]
      default:     ttl_ok = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Match result, one cycle after the frame is offered

  logic hit;

  assign hit = proto_ok && icmp_ok && udp_ok && tcp_ok && ttl_ok; // [R16]

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      match_valid <= 1'b0;
      match_hit   <= 1'b0;
    end else begin
      match_valid <= frm_valid;
      match_hit   <= frm_valid && hit; // [R16]
    end
  end

  // Counter wraps; software samples differences, so saturation buys nothing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hit_count <= 16'h0000;
      last_hit  <= 1'b0;
    end else if (frm_valid) begin
      last_hit <= hit;
      if (hit) begin
        hit_count <= hit_count + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Protection bits carry no meaning here

  logic unused_prot;

  assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

endmodule

// File: verif/alm_matcher_assertions.sv
// Port-level property checker for the layer-4 field matcher
`timescale 1ns/100ps
module alm_matcher_chk
  import alm_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [5:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        frm_valid,
  input wire logic        match_valid,
  input wire logic        match_hit
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  match_lat_a: assert property (frm_valid |=> match_valid)
    else $error("no verdict one cycle after a frame");
  match_idle_a: assert property (!frm_valid |=> !match_valid && !match_hit)
    else $error("verdict without a frame");
  hit_qual_a: assert property (match_hit |-> match_valid)
    else $error("hit outside a verdict cycle");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  read_ans_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rd_unmap_a: assert property (s_axi_arvalid && s_axi_arready
    && (s_axi_araddr > 6'h20 || s_axi_araddr[1:0] != 2'h0)
    |=> s_axi_rresp == ALM_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  wr_ans_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write accepted before response");
  hit_seen_c: cover property (match_valid && match_hit);
  miss_seen_c: cover property (match_valid && !match_hit);
  wr_err_c: cover property (s_axi_bvalid && s_axi_bresp == ALM_RESP_SLVERR);
endmodule
bind alm_matcher alm_matcher_chk i_chk (.clk(clk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .frm_valid(frm_valid), .match_valid(match_valid), .match_hit(match_hit));

// File: verif/alm_frm_src.sv
// Frame parser model feeding parsed header fields
`timescale 1ns/100ps
module alm_frm_src (
  input  wire logic  clk,
  output logic       frm_valid,
  output logic       frm_ipv4,
  output logic [7:0] frm_proto,
  output logic [7:0] frm_icmp_type,
  output logic [7:0] frm_icmp_code,
  output logic [15:0] frm_src_port,
  output logic [15:0] frm_dst_port,
  output logic [5:0] frm_tcp_flags,
  output logic [7:0] frm_ttl
);
  initial begin
    frm_valid = 1'b0;
    {frm_ipv4, frm_proto, frm_icmp_type, frm_icmp_code, frm_src_port, frm_dst_port, frm_tcp_flags, frm_ttl} = '0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Fields are inverted once the frame is gone, so stale values never pass for live ones
  task automatic send(input logic v4, input logic [7:0] pr, input logic [15:0] ic, input logic [15:0] sp,
                      input logic [15:0] dp, input logic [5:0] fl, input logic [7:0] tl);
    @(posedge clk);
    frm_valid <= 1'b1;
    {frm_ipv4, frm_proto, frm_icmp_type, frm_icmp_code, frm_src_port, frm_dst_port, frm_tcp_flags, frm_ttl}
      <= {v4, pr, ic, sp, dp, fl, tl};
    @(posedge clk);
    frm_valid <= 1'b0;
    {frm_ipv4, frm_proto, frm_icmp_type, frm_icmp_code, frm_src_port, frm_dst_port, frm_tcp_flags, frm_ttl}
      <= ~{v4, pr, ic, sp, dp, fl, tl};
  endtask
endmodule

// File: verif/tb.sv
// Self-checking testbench for the layer-4 field matcher
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb;
  import alm_pkg::*;
  localparam logic [1:0] rsp_ok = ALM_RESP_OKAY;
  localparam logic [1:0] rsp_err = ALM_RESP_SLVERR;
  logic clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic fv, f4, mv, mh;
  logic [7:0] fp, ft, fc, fttl;
  logic [15:0] fs, fd;
  logic [5:0] ff;
  logic [3:0] ws;
  int failures, num_checks;
  initial begin clk = 1'b0; forever #25 clk = ~clk; end
  alm_matcher i_dut (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(ws),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .frm_valid(fv), .frm_ipv4(f4), .frm_proto(fp), .frm_icmp_type(ft),
    .frm_icmp_code(fc), .frm_src_port(fs), .frm_dst_port(fd), .frm_tcp_flags(ff), .frm_ttl(fttl),
    .match_valid(mv), .match_hit(mh));
  alm_frm_src i_src (.clk(clk), .frm_valid(fv), .frm_ipv4(f4), .frm_proto(fp), .frm_icmp_type(ft),
    .frm_icmp_code(fc), .frm_src_port(fs), .frm_dst_port(fd), .frm_tcp_flags(ff), .frm_ttl(fttl));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (awvalid && awready) begin aw_done = 1'b1; awvalid <= 1'b0; end
      if (wvalid && wready) begin w_done = 1'b1; wvalid <= 1'b0; end
    end
    while (!bvalid) @(posedge clk);
    bready <= 1'b0;
    `CHK(bresp, er)
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] ed, input logic [31:0] m, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clk);
    rready <= 1'b0;
    `CHK(rdata & m, ed)
    `CHK(rresp, er)
  endtask
  // Verdict is looked at in the one cycle that it stands
  task automatic fr(input logic v4, input logic [7:0] pr, input logic [15:0] ic, input logic [15:0] sp,
                    input logic [15:0] dp, input logic [5:0] fl, input logic [7:0] tl, input logic eh);
    i_src.send(v4, pr, ic, sp, dp, fl, tl);
    #1;
    `CHK(mv, 1'b1)
    `CHK(mh, eh)
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    for (int i = 0; i < 9; i++) rd(6'(4 * i), 32'h0, 32'hFFFFFFFF, rsp_ok);
    fr(1'b0, 8'h06, 16'hFFFF, 16'h1234, 16'h0000, 6'h3F, 8'h00, 1'b1);
  endtask
  task automatic t_icmp;
    wr(ALM_REG_PROTO, 32'h1, rsp_ok);
    wr(ALM_REG_ICMP, 32'h0000FF03, rsp_ok);
    fr(1'b1, ALM_IPP_ICMP, 16'hFF00, 16'h0, 16'h0, 6'h0, 8'h40, 1'b1);
    fr(1'b1, ALM_IPP_ICMP, 16'hFE00, 16'h0, 16'h0, 6'h0, 8'h40, 1'b0);
    fr(1'b1, ALM_IPP_ICMP, 16'hFF01, 16'h0, 16'h0, 6'h0, 8'h40, 1'b0);
    fr(1'b1, ALM_IPP_UDP, 16'hFF00, 16'h0, 16'h0, 6'h0, 8'h40, 1'b0);
  endtask
  task automatic t_ports;
    wr(ALM_REG_PROTO, 32'h2, rsp_ok);
    wr(ALM_REG_PMODE, 32'h69, rsp_ok);
    wr(6'h10, 32'h00000035, rsp_ok);
    wr(6'h14, 32'h10FF1000, rsp_ok);
    wr(6'h18, 32'hFFFF0000, rsp_ok);
    wr(6'h1C, 32'h0000FFFF, rsp_ok);
    fr(1'b1, ALM_IPP_UDP, 16'h0, 16'h0035, 16'h1000, 6'h0, 8'h40, 1'b1);
    fr(1'b1, ALM_IPP_UDP, 16'h0, 16'h0035, 16'h10FF, 6'h0, 8'h40, 1'b1);
    fr(1'b1, ALM_IPP_UDP, 16'h0, 16'h0035, 16'h0FFF, 6'h0, 8'h40, 1'b0);
    fr(1'b1, ALM_IPP_UDP, 16'h0, 16'h0035, 16'h1100, 6'h0, 8'h40, 1'b0);
    fr(1'b1, ALM_IPP_UDP, 16'h0, 16'h0034, 16'h1000, 6'h0, 8'h40, 1'b0);
    fr(1'b1, ALM_IPP_TCP, 16'h0, 16'h0035, 16'h1000, 6'h0, 8'h40, 1'b0);
    wr(ALM_REG_PROTO, 32'h3, rsp_ok);
    fr(1'b1, ALM_IPP_TCP, 16'h0, 16'h0000, 16'hFFFF, 6'h0, 8'h40, 1'b1);
    fr(1'b1, ALM_IPP_TCP, 16'h0, 16'hFFFF, 16'hFFFF, 6'h0, 8'h40, 1'b1);
    fr(1'b1, ALM_IPP_TCP, 16'h0, 16'h0000, 16'hFFFE, 6'h0, 8'h40, 1'b0);
  endtask
  task automatic t_flags;
    wr(ALM_REG_PMODE, 32'h0, rsp_ok);
    for (int i = 0; i < ALM_NFLAG; i++) begin
      wr(ALM_REG_FLAGS, 32'h1 << (2 * i), rsp_ok);
      fr(1'b1, ALM_IPP_TCP, 16'h0, 16'h0, 16'h0, 6'h1 << i, 8'h40, 1'b1);
      fr(1'b1, ALM_IPP_TCP, 16'h0, 16'h0, 16'h0, ~(6'h1 << i), 8'h40, 1'b0);
      wr(ALM_REG_FLAGS, 32'h2 << (2 * i), rsp_ok);
      fr(1'b1, ALM_IPP_TCP, 16'h0, 16'h0, 16'h0, ~(6'h1 << i), 8'h40, 1'b1);
      fr(1'b1, ALM_IPP_TCP, 16'h0, 16'h0, 16'h0, 6'h1 << i, 8'h40, 1'b0);
    end
    wr(ALM_REG_FLAGS, 32'h0, rsp_ok);
  endtask
  task automatic t_ttl;
    wr(ALM_REG_PROTO, 32'h4, rsp_ok);
    fr(1'b1, 8'h2F, 16'h0, 16'h0, 16'h0, 6'h0, 8'h40, 1'b1);
    fr(1'b1, ALM_IPP_UDP, 16'h0, 16'h0, 16'h0, 6'h0, 8'h40, 1'b0);
    wr(ALM_REG_PROTO, 32'h10, rsp_ok);
    fr(1'b1, ALM_IPP_UDP, 16'h0, 16'h0, 16'h0, 6'h0, 8'h01, 1'b1);
    fr(1'b1, ALM_IPP_UDP, 16'h0, 16'h0, 16'h0, 6'h0, 8'h00, 1'b0);
    wr(ALM_REG_PROTO, 32'h20, rsp_ok);
    fr(1'b1, ALM_IPP_UDP, 16'h0, 16'h0, 16'h0, 6'h0, 8'h00, 1'b1);
    fr(1'b1, ALM_IPP_UDP, 16'h0, 16'h0, 16'h0, 6'h0, 8'hFF, 1'b0);
  endtask
  // Refused accesses must leave the entry untouched
  task automatic t_bus;
    wr(6'h24, 32'hFFFFFFFF, rsp_err);
    rd(6'h24, 32'h0, 32'hFFFFFFFF, rsp_err);
    rd(6'h02, 32'h0, 32'hFFFFFFFF, rsp_err);
    wr(6'h11, 32'hFFFFFFFF, rsp_err);
    rd(6'h11, 32'h0, 32'hFFFFFFFF, rsp_err);
    // Only byte 1 of the UDP source word may change
    ws <= 4'h2;
    wr(ALM_REG_PORT0, 32'hAAAAAAAA, rsp_ok);
    ws <= 4'hF;
    rd(ALM_REG_PORT0, 32'h0000AA35, 32'hFFFFFFFF, rsp_ok);
    rd(ALM_REG_PROTO, 32'h20, 32'hFFFFFFFF, rsp_ok);
    rd(ALM_REG_STATUS, 32'h15, 32'hFFFFFFFF, rsp_ok);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    ws = 4'hF;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset;
    t_icmp;
    t_ports;
    t_flags;
    t_ttl;
    t_bus;
    report_and_stop;
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    report_and_stop;
  end
endmodule
